// ===== include/fansr_regs.vh
/*
  Register map, field positions, reset values and bus answer codes of the
  fiber auto-negotiation status bank. Assumes inclusion by every design file
  of the bank that uses its names. Word indices are multiplied by four to form byte addresses.
*/
`ifndef FANSR_REGS_VH
`define FANSR_REGS_VH

// Word indices of the registers; byte address is four times the index.
`define FANSR_IDX_PARTNER_ABILITY 14'h0c05
`define FANSR_IDX_EXPANSION       14'h0c06
`define FANSR_IDX_CONTROL         14'h0c20
`define FANSR_IDX_IRQ_STATUS      14'h0c21
`define FANSR_IDX_IRQ_MASK        14'h0c22

// Partner ability fields, placed as in the received base page.
`define FANSR_ABIL_HALF_BIT       6
`define FANSR_ABIL_FULL_BIT       5
`define FANSR_PAGE_NEXT_PAGE_BIT  15

// Expansion fields.
`define FANSR_EXP_PARTNER_NP_BIT  3
`define FANSR_EXP_LOCAL_NP_BIT    2
`define FANSR_EXP_NEW_PAGE_BIT    1
`define FANSR_EXP_PARTNER_AN_BIT  0

// Control field: one selects SGMII operation, zero selects fiber 1000BASE-X.
`define FANSR_CTRL_SGMII_BIT      0

// Interrupt status and mask fields.
`define FANSR_IRQ_BASE_PAGE_BIT   0
`define FANSR_IRQ_NEXT_PAGE_BIT   1
`define FANSR_IRQ_RESTART_BIT     2
`define FANSR_IRQ_WIDTH           3

// Reset values.
`define FANSR_RST_EXPANSION       16'h0000
`define FANSR_RST_ABILITY         16'h0000
`define FANSR_RST_CONTROL         1'b0
`define FANSR_RST_IRQ_MASK        3'h0

// AXI4-Lite answer codes.
`define FANSR_RESP_OKAY           2'h0
`define FANSR_RESP_SLVERR         2'h2

`endif

// ===== hw/fansr_sticky.v
/*
  A row of sticky flags: each bit is set by a one-cycle event and cleared as a
  whole by a clear strobe. Assumes the clock and synchronous active-low reset
  of the register bank.
*/
`timescale 1ns/1ps
`default_nettype none

module fansr_sticky #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] set,
  input  wire         clr,
  output wire [W-1:0] q
);

  reg [W-1:0] flag_q;
  wire [W-1:0] flag_d;

  // An event in the same cycle as the clear survives it, so no event is lost.
  assign flag_d = (flag_q & ~{W{clr}}) | set;

  // Synchronous reset to all zero.
  always @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= {W{1'b0}};
    end else begin
      flag_q <= flag_d;
    end
  end

  assign q = flag_q;

endmodule

`default_nettype wire

// ===== hw/fansr_page_track.v
/*
  Tracks what the link partner's pages tell about it: its duplex abilities,
  whether it can negotiate and whether it can exchange next pages. Assumes
  the negotiation logic gives one-cycle strobes for each page and for entry
  into the enable state, all synchronous to the bank clock.
*/
`timescale 1ns/1ps
`default_nettype none

`include "fansr_regs.vh"

module fansr_page_track (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        page_valid,
  input  wire        page_base,
  input  wire [15:0] page_word,
  input  wire        enable_enter,
  output wire        partner_half_duplex_able,
  output wire        partner_full_duplex_able,
  output wire        partner_next_page_able,
  output wire        partner_negotiation_able
);

  reg  half_q;
  reg  full_q;
  reg  np_able_q;
  reg  an_able_q;
  wire base_rx;

  assign base_rx = page_valid & page_base;

  // Abilities follow the latest base page; a page arriving together with
  // entry into the enable state belongs to the new round and wins.
  always @(posedge clk) begin
    if (!rst_n) begin
      half_q    <= 1'b0;
      full_q    <= 1'b0;
      np_able_q <= 1'b0;
      an_able_q <= 1'b0;
    end else begin
      if (base_rx) begin
        half_q <= page_word[`FANSR_ABIL_HALF_BIT]; // [RL1]
        full_q <= page_word[`FANSR_ABIL_FULL_BIT]; // [RL2]
      end
      if (base_rx && page_word[`FANSR_PAGE_NEXT_PAGE_BIT]) begin
        np_able_q <= 1'b1; // [RL3]
      end else if (enable_enter) begin
        np_able_q <= 1'b0; // [RL4]
      end
      if (base_rx) begin
        an_able_q <= 1'b1; // [RL9]
      end else if (enable_enter) begin
        an_able_q <= 1'b0; // [RL9]
      end
    end
  end

  assign partner_half_duplex_able = half_q;
  assign partner_full_duplex_able = full_q;
  assign partner_next_page_able   = np_able_q;
  assign partner_negotiation_able = an_able_q;

endmodule

`default_nettype wire

// ===== hw/fansr_top.v
/*
  Fiber and SGMII auto-negotiation status register bank behind an AXI4-Lite
  slave. Holds the partner ability register, the expansion register, a mode
  control register and an interrupt status and mask pair. Assumes page and
  enable-state strobes from the negotiation logic synchronous to SYS_CLK, and
  an AXI4-Lite master on the same clock.
*/
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

`include "fansr_regs.vh"

// Functional notes
// (RL1) Partner ability bit 6 shows whether the partner offers 1000BASE-X half duplex.
// (RL2) Partner ability bit 5 shows whether the partner offers 1000BASE-X full duplex.
// (RL3) Expansion bit 3 sets when a base page arrives with its next-page flag, bit 15, at one.
// (RL4) Expansion bit 3 clears when negotiation enters the enable state.
// (RL5) In SGMII operation the partner sends base pages with the next-page flag at zero.
// (RL6) Expansion bit 2 reads one in fiber 1000BASE-X mode and zero in SGMII mode.
// (RL7) Expansion bit 1 latches at one whenever any new page arrives and holds until cleared.
// (RL8) Reading the expansion register returns bit 1 and then clears it.
// (RL9) Expansion bit 0 sets on any base page and clears when negotiation enters the enable state.
// (RL10) Expansion bits 15 to 4 read zero and the register resets to zero; here bit 2 resets to one, so reset reads 0x0004.
// (RL11) Partner ability bits 4 to 0 read zero and ignore writes.
module fansr_top (
  input  wire        SYS_CLK,
  input  wire        RST_N,
  input  wire [15:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output wire [1:0]  S_AXI_BRESP,
  output wire        S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [15:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0]  S_AXI_RRESP,
  output wire        S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire        PAGE_RX_VALID,
  input  wire        PAGE_RX_BASE,
  input  wire [15:0] PAGE_RX_WORD,
  input  wire        NEG_ENABLE_ENTER,
  output wire        IRQ
);

  // Write channel state.
  reg        awready_q;
  reg        wready_q;
  reg        aw_held_q;
  reg        w_held_q;
  reg [13:0] wr_idx_q;
  reg [15:0] wr_data_q;
  reg [1:0]  wr_strb_q;
  reg        bvalid_q;
  reg [1:0]  bresp_q;

  // Read channel state.
  reg        arready_q;
  reg        rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0]  rresp_q;

  // Software-owned registers and the interrupt flop.
  reg                        sgmii_mode_q;
  reg [`FANSR_IRQ_WIDTH-1:0] irq_mask_q;
  reg                        irq_q;

  // Combinational helpers.
  wire                        aw_hs;
  wire                        w_hs;
  wire                        ar_hs;
  wire                        wr_go;
  wire [13:0]                 ar_idx;
  wire                        read_expansion;
  wire                        read_irq_status;
  wire                        partner_half_duplex_able;
  wire                        partner_full_duplex_able;
  wire                        partner_next_page_able;
  wire                        partner_negotiation_able;
  wire                        local_next_page_able;
  wire [0:0]                  new_page_received;
  wire [`FANSR_IRQ_WIDTH-1:0] irq_events;
  wire [`FANSR_IRQ_WIDTH-1:0] irq_status;
  wire [15:0]                 ability_word;
  wire [15:0]                 expansion_word;
  wire [15:0]                 control_word;
  wire [15:0]                 irq_status_word;
  wire [15:0]                 irq_mask_word;
  reg  [15:0]                 rd_word;
  reg  [1:0]                  rd_resp;
  reg                         wr_mapped;

  // Handshakes on the AW, W and AR channels happen when valid meets a ready from a flop.
  assign aw_hs  = S_AXI_AWVALID & awready_q;
  assign w_hs   = S_AXI_WVALID & wready_q;
  assign ar_hs  = S_AXI_ARVALID & arready_q;
  assign wr_go  = aw_held_q & w_held_q & ~bvalid_q;
  assign ar_idx = S_AXI_ARADDR[15:2];

  // Reads with side effects are recognised when the address is taken, so the
  // value captured for the answer is the one before the clear.
  assign read_expansion  = ar_hs & (ar_idx == `FANSR_IDX_EXPANSION);
  assign read_irq_status = ar_hs & (ar_idx == `FANSR_IDX_IRQ_STATUS);

  // Partner ability and negotiation tracking.
  fansr_page_track u_page_track (
    .clk                      (SYS_CLK),
    .rst_n                    (RST_N),
    .page_valid               (PAGE_RX_VALID),
    .page_base                (PAGE_RX_BASE),
    .page_word                (PAGE_RX_WORD),
    .enable_enter             (NEG_ENABLE_ENTER),
    .partner_half_duplex_able (partner_half_duplex_able),
    .partner_full_duplex_able (partner_full_duplex_able),
    .partner_next_page_able   (partner_next_page_able),
    .partner_negotiation_able (partner_negotiation_able)
  );

  // New page flag: any page sets it, a read of the expansion register clears
  // it, and a page in the clearing cycle keeps it set.
  fansr_sticky #(
    .W (1)
  ) u_new_page (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .set   (PAGE_RX_VALID),      // [RL7]
    .clr   (read_expansion),     // [RL8]
    .q     (new_page_received)
  );

  // Interrupt events: base page, next page and restart of negotiation.
  assign irq_events[`FANSR_IRQ_BASE_PAGE_BIT] = PAGE_RX_VALID & PAGE_RX_BASE;
  assign irq_events[`FANSR_IRQ_NEXT_PAGE_BIT] = PAGE_RX_VALID & ~PAGE_RX_BASE;
  assign irq_events[`FANSR_IRQ_RESTART_BIT]   = NEG_ENABLE_ENTER;

  // Interrupt status clears on read; events in that cycle stay pending.
  fansr_sticky #(
    .W (`FANSR_IRQ_WIDTH)
  ) u_irq_status (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .set   (irq_events),
    .clr   (read_irq_status),
    .q     (irq_status)
  );

  // Local next-page ability follows the operating mode; SGMII has no next
  // pages, so the partner is trusted to keep its next-page flag clear there.
  assign local_next_page_able = ~sgmii_mode_q; // [RL6] [RL5]

  // Register images as software sees them; unlisted bits are zero.
  assign ability_word = {9'h000,
                         partner_half_duplex_able,   // [RL1]
                         partner_full_duplex_able,   // [RL2]
                         5'h00};                     // [RL11]
  assign expansion_word = {12'h000,                  // [RL10]
                           partner_next_page_able,   // [RL3]
                           local_next_page_able,     // [RL6]
                           new_page_received[0],     // [RL7]
                           partner_negotiation_able}; // [RL9]
  assign control_word    = {15'h0000, sgmii_mode_q};
  assign irq_status_word = {13'h0000, irq_status};
  assign irq_mask_word   = {13'h0000, irq_mask_q};

  // Read decode; an unmapped index answers zero with a slave error.
  always @* begin
    rd_word = 16'h0000;
    rd_resp = `FANSR_RESP_OKAY;
    case (ar_idx)
      `FANSR_IDX_PARTNER_ABILITY: begin
        rd_word = ability_word;
      end
      `FANSR_IDX_EXPANSION: begin
        rd_word = expansion_word;
      end
      `FANSR_IDX_CONTROL: begin
        rd_word = control_word;
      end
      `FANSR_IDX_IRQ_STATUS: begin
        rd_word = irq_status_word;
      end
      `FANSR_IDX_IRQ_MASK: begin
        rd_word = irq_mask_word;
      end
      default: begin
        rd_resp = `FANSR_RESP_SLVERR;
      end
    endcase
  end

  // Write decode; read-only registers take the write and keep their value.
  always @* begin
    case (wr_idx_q)
      `FANSR_IDX_PARTNER_ABILITY: begin
        wr_mapped = 1'b1; // [RL11]
      end
      `FANSR_IDX_EXPANSION: begin
        wr_mapped = 1'b1; // [RL10]
      end
      `FANSR_IDX_CONTROL: begin
        wr_mapped = 1'b1;
      end
      `FANSR_IDX_IRQ_STATUS: begin
        wr_mapped = 1'b1;
      end
      `FANSR_IDX_IRQ_MASK: begin
        wr_mapped = 1'b1;
      end
      default: begin
        wr_mapped = 1'b0;
      end
    endcase
  end

  // Write address and data are taken in either order and held until both
  // have come; the response is raised once both are present.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      wr_idx_q  <= 14'h0000;
      wr_data_q <= 16'h0000;
      wr_strb_q <= 2'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `FANSR_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_held_q <= 1'b1;
        awready_q <= 1'b0;
        wr_idx_q  <= S_AXI_AWADDR[15:2];
      end else if (!aw_held_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (w_hs) begin
        w_held_q  <= 1'b1;
        wready_q  <= 1'b0;
        wr_data_q <= S_AXI_WDATA[15:0];
        wr_strb_q <= S_AXI_WSTRB[1:0];
      end else if (!w_held_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_mapped ? `FANSR_RESP_OKAY : `FANSR_RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Software-owned fields take the low byte lane only; the upper bits of
  // these registers are zero, so the other lanes carry nothing to store.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sgmii_mode_q <= `FANSR_RST_CONTROL;
      irq_mask_q   <= `FANSR_RST_IRQ_MASK;
    end else if (wr_go && wr_strb_q[0]) begin
      if (wr_idx_q == `FANSR_IDX_CONTROL) begin
        sgmii_mode_q <= wr_data_q[`FANSR_CTRL_SGMII_BIT];
      end
      if (wr_idx_q == `FANSR_IDX_IRQ_MASK) begin
        irq_mask_q <= wr_data_q[`FANSR_IRQ_WIDTH-1:0];
      end
    end
  end

  // One read at a time: the address is refused while an answer is pending,
  // which keeps read-to-clear from firing twice for one answer.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `FANSR_RESP_OKAY;
    end else begin
      if (ar_hs) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= {16'h0000, rd_word}; // [RL8]
        rresp_q   <= rd_resp;
      end else if (rvalid_q && S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  // Interrupt is a level from a flop: high while any unmasked flag is set.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status & irq_mask_q);
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY  = wready_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign IRQ           = irq_q;

endmodule

`default_nettype wire

// ===== sim/fansr_chk_asserts.sv
/*
  Checker for the fansr_top bank: read data against a shadow of the pages.
  Assumes fansr_regs.vh on the include path and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fansr_regs.vh"
module fansr_chk (
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic [15:0] S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        PAGE_RX_VALID,
  input wire logic        PAGE_RX_BASE,
  input wire logic [15:0] PAGE_RX_WORD,
  input wire logic        NEG_ENABLE_ENTER
);
  logic       hd_q, fd_q, np_q, pr_q, an_q, ab_q, ex_q;
  logic [4:0] e_q;
  wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  wire bp    = PAGE_RX_VALID && PAGE_RX_BASE;
  wire rd_ex = ar_hs && (S_AXI_ARADDR[15:2] == `FANSR_IDX_EXPANSION);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // Shadow of the page flags; a base page beats negotiation_enable_state entry and a read in the same cycle.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      {hd_q, fd_q, np_q, pr_q, an_q, ab_q, ex_q, e_q} <= 12'h000;
    end else begin
      if (bp) {hd_q, fd_q} <= PAGE_RX_WORD[6:5];
      np_q <= (bp && PAGE_RX_WORD[15]) ? 1'h1 : (NEG_ENABLE_ENTER ? 1'h0 : np_q);
      an_q <= bp ? 1'h1 : (NEG_ENABLE_ENTER ? 1'h0 : an_q);
      pr_q <= PAGE_RX_VALID ? 1'h1 : (rd_ex ? 1'h0 : pr_q);
      if (ar_hs) begin
        ab_q <= S_AXI_ARADDR[15:2] == `FANSR_IDX_PARTNER_ABILITY;
        ex_q <= S_AXI_ARADDR[15:2] == `FANSR_IDX_EXPANSION;
        e_q  <= {hd_q, fd_q, np_q, pr_q, an_q}; // Value before any clear.
      end
    end
  end
  sequence s_ab; $rose(S_AXI_RVALID) && ab_q; endsequence
  sequence s_ex; $rose(S_AXI_RVALID) && ex_q; endsequence
  property p_half; s_ab |-> S_AXI_RDATA[6] == e_q[4]; endproperty
  a_half: assert property (p_half) else $error("half duplex bit wrong");
  property p_full; s_ab |-> S_AXI_RDATA[5] == e_q[3]; endproperty
  a_full: assert property (p_full) else $error("full duplex bit wrong");
  property p_ab_rsvd; s_ab |-> S_AXI_RDATA[4:0] == 5'h00; endproperty
  a_ab_rsvd: assert property (p_ab_rsvd) else $error("ability low bits set");
  property p_np; s_ex |-> S_AXI_RDATA[3] == e_q[2]; endproperty
  a_np: assert property (p_np) else $error("partner next page bit wrong");
  property p_pr; s_ex |-> S_AXI_RDATA[1] == e_q[1]; endproperty
  a_pr: assert property (p_pr) else $error("new page bit wrong");
  property p_an; s_ex |-> S_AXI_RDATA[0] == e_q[0]; endproperty
  a_an: assert property (p_an) else $error("negotiation able bit wrong");
  property p_ex_rsvd; s_ex |-> S_AXI_RDATA[15:4] == 12'h000; endproperty
  a_ex_rsvd: assert property (p_ex_rsvd) else $error("expansion high bits set");
  property p_rd_lat; ar_hs |-> ##1 S_AXI_RVALID && S_AXI_RDATA[31:16] == 16'h0000; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late or wide");
  c_base: cover property (bp);
  c_rd_ex: cover property (rd_ex);
  c_both: cover property (bp && NEG_ENABLE_ENTER);
endmodule
bind fansr_top fansr_chk i_chk (.SYS_CLK, .RST_N, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RVALID, .PAGE_RX_VALID, .PAGE_RX_BASE, .PAGE_RX_WORD, .NEG_ENABLE_ENTER);
`default_nettype wire

// ===== sim/fansr_lp.sv
/*
  Link partner model: sends pages and enable-state strobes one cycle long.
  Assumes the bench calls drive from its main sequence on the bank clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fansr_lp (
  input  wire logic        clk,
  output logic             valid,
  output logic             base,
  output logic [15:0]      word,
  output logic             enter
);
  logic sgmii;
  // Quiet lines at start; the bench sets sgmii to mimic that mode.
  initial begin
    {valid, base, word, enter, sgmii} = 20'h00000;
  end
  // One strobe cycle; the word is inverted after it so a stale page never looks fresh.
  task automatic drive(input logic v, input logic b, input logic e, input logic [15:0] w);
    @(posedge clk);
    valid <= v;
    base  <= b;
    word  <= (sgmii && b) ? {1'h0, w[14:0]} : w;
    enter <= e;
    @(posedge clk);
    valid <= 1'h0;
    base  <= ~b;
    word  <= ~word;
    enter <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== sim/fiber_autoneg_status_regs_tb.sv
/*
  Self-checking bench for fansr_top over AXI4-Lite with a link partner model.
  Assumes fansr_regs.vh on the include path and the checker bound in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fansr_regs.vh"
module fiber_autoneg_status_regs_tb;
  localparam logic [15:0] A_AB = {`FANSR_IDX_PARTNER_ABILITY, 2'h0};
  localparam logic [15:0] A_EX = {`FANSR_IDX_EXPANSION, 2'h0};
  localparam logic [15:0] A_CT = {`FANSR_IDX_CONTROL, 2'h0};
  localparam logic [15:0] A_IS = {`FANSR_IDX_IRQ_STATUS, 2'h0};
  localparam logic [15:0] A_IM = {`FANSR_IDX_IRQ_MASK, 2'h0};
  localparam logic [15:0] A_NO = 16'h0100;
  localparam logic [1:0]  OK   = `FANSR_RESP_OKAY;
  localparam logic [1:0]  ERR  = `FANSR_RESP_SLVERR;
  logic        clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000, pw;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, irq, pv, pb, pe;
  int          failures = 0, tests_run = 0;
  always #20 clk = ~clk;
  fansr_top i_dut (.SYS_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PAGE_RX_VALID(pv),
    .PAGE_RX_BASE(pb), .PAGE_RX_WORD(pw), .NEG_ENABLE_ENTER(pe), .IRQ(irq));
  fansr_lp i_lp (.clk(clk), .valid(pv), .base(pb), .word(pw), .enter(pe));
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t data %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t resp %h exp %h", $time, got, exp);
    end
  endtask
  // A bus answer that never comes ends the run rather than hanging it.
  task automatic hang();
    failures++;
    $display("MISMATCH t=%0t no answer", $time);
    end_of_test();
  endtask
  // Address and data go out together; each is dropped only once taken.
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge clk);
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awv, wv, bready} <= 3'h7;
    repeat (50) begin
      @(posedge clk);
      if (awv && awready) awv <= 1'h0;
      if (wv && wready) wv <= 1'h0;
      if (bvalid) begin
        bready <= 1'h0;
        chk_resp(bresp, er);
        return;
      end
    end
    hang();
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    {arv, rready} <= 2'h3;
    repeat (50) begin
      @(posedge clk);
      if (arv && arready) arv <= 1'h0;
      if (rvalid) begin
        {d, r} = {rdata, rresp};
        rready <= 1'h0;
        return;
      end
    end
    hang();
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk_data(d, {16'h0000, e});
    chk_resp(r, OK);
  endtask
  // Lets the page land and the one-cycle-late interrupt settle, then looks at it.
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk);
    #1;
    chk_data({31'h0, irq}, {31'h0, e});
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    rd_chk(A_EX, 16'h0004);
    rd_chk(A_AB, 16'h0000);
    rd(A_NO, d, r);
    chk_resp(r, ERR);
    $display("test reset_values done");
    i_lp.drive(1'h1, 1'h1, 1'h0, 16'h8060);
    rd_chk(A_AB, 16'h0060);
    rd_chk(A_EX, 16'h000f);
    rd_chk(A_EX, 16'h000d);
    i_lp.drive(1'h0, 1'h0, 1'h1, 16'h0000);
    rd_chk(A_EX, 16'h0004);
    i_lp.drive(1'h1, 1'h0, 1'h0, 16'hffff);
    rd_chk(A_EX, 16'h0006);
    rd_chk(A_AB, 16'h0060);
    i_lp.drive(1'h1, 1'h1, 1'h1, 16'h0040);
    rd_chk(A_EX, 16'h0007);
    rd_chk(A_AB, 16'h0040);
    $display("test pages done");
    wr(A_AB, 32'h0000ffff, 4'hf, OK);
    rd_chk(A_AB, 16'h0040);
    wr(A_EX, 32'h0000ffff, 4'hf, OK);
    rd_chk(A_EX, 16'h0005);
    wr(A_CT, 32'h00000001, 4'h1, OK);
    rd_chk(A_CT, 16'h0001);
    i_lp.sgmii = 1'h1;
    i_lp.drive(1'h1, 1'h1, 1'h0, 16'h8020);
    rd_chk(A_EX, 16'h0003);
    rd_chk(A_AB, 16'h0020);
    wr(A_CT, 32'h00000000, 4'h1, OK);
    rd_chk(A_CT, 16'h0000);
    rd_chk(A_EX, 16'h0005);
    i_lp.sgmii = 1'h0;
    $display("test writes_and_mode done");
    rd(A_IS, d, r);
    wr(A_IM, 32'h00000001, 4'h0, OK);
    rd_chk(A_IM, 16'h0000);
    wr(A_IM, 32'h00000001, 4'h1, OK);
    rd_chk(A_IM, 16'h0001);
    i_lp.drive(1'h1, 1'h0, 1'h0, 16'h1234);
    irq_chk(1'h0);
    i_lp.drive(1'h1, 1'h1, 1'h0, 16'h0020);
    irq_chk(1'h1);
    i_lp.drive(1'h0, 1'h0, 1'h1, 16'h0000);
    rd_chk(A_IS, 16'h0007);
    irq_chk(1'h0);
    wr(A_NO, 32'h00000000, 4'hf, ERR);
    $display("test interrupts done");
    end_of_test();
  end
endmodule
`default_nettype wire
